/* rtl/ctw_defs.vh */
// constants for the can transceiver mode and wake control block
// assumes 50 mhz i_mclk; included by the single design file
`ifndef CTW_DEFS_VH
`define CTW_DEFS_VH
`define CTW_CLK_MHZ 50
// modes
`define CTW_MODE_OFF 2'h0
`define CTW_MODE_TXRX 2'h1
`define CTW_MODE_RXONLY 2'h2
`define CTW_MODE_SLEEP 2'h3
// slew settings, fastest is default
`define CTW_SLEW_FAST 2'h0
`define CTW_SLEW_MED 2'h1
`define CTW_SLEW_SLOW 2'h2
// times
`define CTW_VALID_PULSE_NS 500
`define CTW_SINGLE_PULSE_NS 2000
`define CTW_WINDOW_US 120
`define CTW_TXD_DOM_US 300
// cycle counts: least times round up
`define CTW_VALID_CYC ((`CTW_VALID_PULSE_NS * `CTW_CLK_MHZ + 999) / 1000 + 1)
`define CTW_SINGLE_CYC ((`CTW_SINGLE_PULSE_NS * `CTW_CLK_MHZ + 999) / 1000)
`define CTW_WINDOW_CYC (`CTW_WINDOW_US * `CTW_CLK_MHZ)
`define CTW_TXD_DOM_CYC (`CTW_TXD_DOM_US * `CTW_CLK_MHZ)
`define CTW_PULSES 2'h3
`define CTW_CNT_W 16
// synchronised pins: txd idles recessive (high), the comparators idle low
`define CTW_NSYNC 3
`define CTW_SYNC_RST 3'h1
`define CTW_PIN_TXD 0
`define CTW_PIN_DIF 1
`define CTW_PIN_WK 2
`endif

/* rtl/ctw_can_wake_ctrl.v */
// can transceiver mode control, slew select, txd dominant timeout, bus wake detect
// assumes digitised bus comparators and host pins asynchronous to i_mclk
//
// Behaviour
// - tx/rx mode: driver and receiver both active
// - receive-only: driver off, receiver on
// - driver enables in normal mode with txd recessive
// - txd high gives recessive drive
// - txd low gives dominant drive
// - rxd high recessive, low dominant
// - three slew settings, fastest by default
// - txd dominant timeout covers twelve bit times
// - sleep: drivers off, inputs grounded, wake receiver
// - bus wake sets flag, pulses interrupt, wakes chip
// - leaving sleep restores recessive bus
// - bus wake can be enabled or disabled
// - default wake needs three valid dominant pulses
// - single-pulse select wakes on 2 us pulse
// - valid pulse over 500 ns, within 120 us
// - split buffer active in tx/rx and receive-only, high-z in sleep and off
// - active modes only with driver supply on
`timescale 1ns/1ns
`default_nettype none
`include "ctw_defs.vh"
module ctw_can_wake_ctrl #(
  parameter [`CTW_CNT_W-1:0] WINDOW_CYC = `CTW_WINDOW_CYC,
  parameter [`CTW_CNT_W-1:0] TXD_DOM_CYC = `CTW_TXD_DOM_CYC
) (
  // clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // chip mode and configuration
  input wire i_chip_normal,
  input wire [1:0] i_can_mode,
  input wire [1:0] i_slew_sel,
  input wire i_slew_cfg_valid,
  input wire i_wake_en,
  input wire i_single_pulse_wake_select,
  input wire i_can_supply_on,
  input wire i_wake_flag_clr,
  // host pins and bus comparators
  input wire i_txd,
  input wire i_bus_diff_dom,
  input wire i_wake_rx_dom,
  // outputs
  output reg o_rxd,
  output reg o_drv_en,
  output reg o_drv_dom,
  output reg o_rx_en,
  output reg o_rin_gnd,
  output reg o_split_en,
  output reg o_wake_rx_en,
  output reg [1:0] o_slew,
  output reg o_txd_dom_timeout,
  output reg o_wake_flag,
  output reg o_wake_int,
  output reg o_chip_wake
);
  // mode decode is shared by several outputs, so it lives in functions
  function is_txrx;
    input [1:0] mode;
    input ok;
    begin
      is_txrx = ok & (mode == `CTW_MODE_TXRX);
    end
  endfunction
  function is_rxonly;
    input [1:0] mode;
    input ok;
    begin
      is_rxonly = ok & (mode == `CTW_MODE_RXONLY);
    end
  endfunction
  function is_listen;
    input [1:0] mode;
    input ok;
    begin
      is_listen = is_txrx(mode, ok) | is_rxonly(mode, ok);
    end
  endfunction
  // the sleep code, or any mode without qualification, counts as sleep; a qualified off mode does not
  function is_sleep;
    input [1:0] mode;
    input ok;
    begin
      is_sleep = (mode == `CTW_MODE_SLEEP) | ~ok;
    end
  endfunction

  // three-stage synchronisers; a change counts once stages 2 and 3 agree
  wire [`CTW_NSYNC-1:0] pin_raw = {i_wake_rx_dom, i_bus_diff_dom, i_txd};
  wire [`CTW_NSYNC-1:0] pin_s;
  // txd resets recessive so the driver can arm without a false timeout
  localparam [`CTW_NSYNC-1:0] SYNC_RST = `CTW_SYNC_RST;
  genvar g;
  generate
    for (g = 0; g < `CTW_NSYNC; g = g + 1) begin : g_sync
      reg [2:0] stage_q;
      reg level_q;
      always @(posedge i_mclk) begin
        if (i_sys_rst) begin
          stage_q <= {3{SYNC_RST[g]}};
          level_q <= SYNC_RST[g];
        end else begin
          stage_q <= {stage_q[1:0], pin_raw[g]};
          if (stage_q[1] == stage_q[2]) begin
            level_q <= stage_q[2];
          end
        end
      end
      assign pin_s[g] = level_q;
    end
  endgenerate
  wire txd_s = pin_s[`CTW_PIN_TXD];
  wire dif_s = pin_s[`CTW_PIN_DIF];
  wire wk_s = pin_s[`CTW_PIN_WK];

  // mode qualification
  wire active_ok = i_chip_normal & i_can_supply_on;
  wire m_txrx = is_txrx(i_can_mode, active_ok);
  wire m_listen = is_listen(i_can_mode, active_ok);
  wire m_sleep = is_sleep(i_can_mode, active_ok);

  // driver arms only from recessive txd; the timeout drops it until txd rises
  reg armed_q;
  reg [`CTW_CNT_W-1:0] dom_cnt_q;
  reg to_q;
  always @(posedge i_mclk) begin
    if (i_sys_rst || !m_txrx) begin
      armed_q <= 1'b0;
    end else if (txd_s) begin
      armed_q <= 1'b1;
    end
  end
  // 300 us dominant limit is at least twelve bits at 40 kbaud
  always @(posedge i_mclk) begin
    if (i_sys_rst || !armed_q || txd_s) begin
      dom_cnt_q <= {`CTW_CNT_W{1'b0}};
    end else if (dom_cnt_q != TXD_DOM_CYC) begin
      dom_cnt_q <= dom_cnt_q + 1'b1;
    end
  end
  always @(posedge i_mclk) begin
    if (i_sys_rst || !m_txrx || txd_s) begin
      to_q <= 1'b0;
    end else if (armed_q && dom_cnt_q == TXD_DOM_CYC) begin
      to_q <= 1'b1;
    end
  end

  // wake detection runs only in sleep with wake enabled
  wire wk_on = m_sleep & i_wake_en;
  // pattern count held clear in single-pulse mode, so no stale count carries over
  wire pat_on = wk_on & ~i_single_pulse_wake_select;
  reg wk_prev_q;
  reg [`CTW_CNT_W-1:0] pw_q;
  reg [`CTW_CNT_W-1:0] win_q;
  reg [1:0] npulse_q;
  reg single_done_q;
  wire fall = wk_prev_q & ~wk_s;
  wire valid_end = fall & (pw_q >= `CTW_VALID_CYC);
  wire win_exp = (npulse_q != 2'h0) & (win_q == WINDOW_CYC);
  wire pat_hit = pat_on & valid_end & ~win_exp &
    (npulse_q == `CTW_PULSES - 2'h1);
  wire one_hit = i_single_pulse_wake_select & wk_s & ~single_done_q &
    (pw_q == `CTW_SINGLE_CYC);
  wire wake_evt = wk_on & (pat_hit | one_hit);
  always @(posedge i_mclk) begin
    if (i_sys_rst || !wk_on) begin
      wk_prev_q <= 1'b0;
    end else begin
      wk_prev_q <= wk_s;
    end
  end
  always @(posedge i_mclk) begin
    if (i_sys_rst || !wk_on || !wk_s) begin
      pw_q <= {`CTW_CNT_W{1'b0}};
    end else if (pw_q != {`CTW_CNT_W{1'b1}}) begin
      pw_q <= pw_q + 1'b1;
    end
  end
  // one wake per long pulse
  always @(posedge i_mclk) begin
    if (i_sys_rst || !wk_on || !wk_s) begin
      single_done_q <= 1'b0;
    end else if (one_hit) begin
      single_done_q <= 1'b1;
    end
  end
  // the window opens at the end of the first valid pulse
  always @(posedge i_mclk) begin
    if (i_sys_rst || !pat_on || pat_hit) begin
      npulse_q <= 2'h0;
    end else if (win_exp) begin
      npulse_q <= valid_end ? 2'h1 : 2'h0;
    end else if (valid_end) begin
      npulse_q <= npulse_q + 2'h1;
    end
  end
  always @(posedge i_mclk) begin
    if (i_sys_rst || !pat_on || pat_hit || win_exp) begin
      win_q <= {`CTW_CNT_W{1'b0}};
    end else if (npulse_q != 2'h0) begin
      win_q <= win_q + 1'b1;
    end
  end

  // registered outputs, one process each
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rx_en <= 1'b0;
    end else begin
      o_rx_en <= m_listen;
    end
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_drv_en <= 1'b0;
    end else begin
      o_drv_en <= armed_q & m_txrx & ~to_q;
    end
  end

  // recessive whenever the driver is off, so leaving sleep is recessive
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_drv_dom <= 1'b0;
    end else begin
      o_drv_dom <= armed_q & m_txrx & ~to_q & ~txd_s;
    end
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rxd <= 1'b1;
    end else begin
      o_rxd <= m_listen ? ~dif_s : 1'b1;
    end
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rin_gnd <= 1'b1;
    end else begin
      o_rin_gnd <= m_sleep;
    end
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_split_en <= 1'b0;
    end else begin
      o_split_en <= m_listen;
    end
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_wake_rx_en <= 1'b0;
    end else begin
      o_wake_rx_en <= wk_on;
    end
  end

  // an unset or reserved code keeps the fastest edge
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_slew <= `CTW_SLEW_FAST;
    end else begin
      o_slew <= (i_slew_cfg_valid && i_slew_sel <= `CTW_SLEW_SLOW) ? i_slew_sel
        : `CTW_SLEW_FAST;
    end
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_txd_dom_timeout <= 1'b0;
    end else begin
      o_txd_dom_timeout <= to_q;
    end
  end

  // set wins over clear
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_wake_flag <= 1'b0;
    end else begin
      o_wake_flag <= wake_evt | (o_wake_flag & ~i_wake_flag_clr);
    end
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_wake_int <= 1'b0;
    end else begin
      o_wake_int <= wake_evt;
    end
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_chip_wake <= 1'b0;
    end else begin
      o_chip_wake <= wake_evt & ~i_chip_normal;
    end
  end
endmodule
`default_nettype wire

/* verification/ctw_chk.sv */
// port checker for the can mode and wake block
// assumes one clock domain and a synchronous reset
`timescale 1ns/1ns
`default_nettype none
module ctw_chk (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_chip_normal,
  input wire logic [1:0] i_can_mode,
  input wire logic i_slew_cfg_valid,
  input wire logic i_wake_en,
  input wire logic i_can_supply_on,
  input wire logic o_rxd,
  input wire logic o_drv_en,
  input wire logic o_drv_dom,
  input wire logic o_rx_en,
  input wire logic o_rin_gnd,
  input wire logic o_split_en,
  input wire logic [1:0] o_slew,
  input wire logic o_wake_flag,
  input wire logic o_wake_int,
  input wire logic o_wake_rx_en,
  input wire logic o_txd_dom_timeout,
  input wire logic o_chip_wake
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // reset term kept in: the edge after release still shows reset values
  wire act = !i_sys_rst && i_chip_normal && i_can_supply_on;
  property p_m1; act && i_can_mode == 2'h1 |=> o_rx_en && o_split_en && !o_rin_gnd; endproperty
  a_m1: assert property (p_m1) else $error("txrx outputs");
  property p_m2; act && i_can_mode == 2'h2 |=> o_rx_en && !o_drv_en && !o_drv_dom; endproperty
  a_m2: assert property (p_m2) else $error("rx only outputs");
  property p_sl; !i_sys_rst && (!act || i_can_mode == 2'h3) |=> o_rin_gnd && !o_split_en
    && !o_drv_en; endproperty
  a_sl: assert property (p_sl) else $error("sleep outputs");
  property p_dom; o_drv_dom |-> o_drv_en; endproperty
  a_dom: assert property (p_dom) else $error("dominant without driver");
  property p_rxd; !o_rx_en |-> o_rxd; endproperty
  a_rxd: assert property (p_rxd) else $error("rxd low with receiver off");
  property p_slw; !i_slew_cfg_valid [*2] |=> o_slew == 2'h0; endproperty
  a_slw: assert property (p_slw) else $error("slew not fastest");
  property p_int; o_wake_int |-> o_wake_flag; endproperty
  a_int: assert property (p_int) else $error("wake pulse without flag");
  property p_wen; !i_wake_en [*3] |=> !o_wake_int; endproperty
  a_wen: assert property (p_wen) else $error("wake while disabled");
  property p_wrx; !i_sys_rst && i_wake_en && (!act || i_can_mode == 2'h3) |=> o_wake_rx_en;
  endproperty
  a_wrx: assert property (p_wrx) else $error("wake receiver off");
  property p_to; o_txd_dom_timeout |-> !o_drv_en && !o_drv_dom; endproperty
  a_to: assert property (p_to) else $error("driver on after timeout");
  property p_cw; o_chip_wake |-> o_wake_int; endproperty
  a_cw: assert property (p_cw) else $error("chip wake without pulse");
  c_to: cover property (o_txd_dom_timeout);
  c_wk: cover property (o_wake_int);
  c_dd: cover property (o_drv_dom);
  c_rg: cover property (o_rin_gnd && !i_sys_rst);
endmodule
bind ctw_can_wake_ctrl ctw_chk i_ctw_chk (.*);
`default_nettype wire

/* verification/ctw_host.sv */
// host can controller model: sends one byte msb first on txd
// assumes go is a one-cycle request while idle
`timescale 1ns/1ns
`default_nettype none
module ctw_host #(parameter int BIT = 10) (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [7:0] i_byte,
  output logic o_txd = 1'b1
);
  int n = 0;
  logic [7:0] sh = 8'hff;
  always @(posedge i_mclk) begin
    if (i_go && n == 0) begin
      sh <= i_byte;
      n <= 8 * BIT;
    end else if (n != 0) begin
      n <= n - 1;
    end
    // idle recessive; eight bits stay short of the twelve-bit timeout
    o_txd <= n == 0 || sh[(n - 1) / BIT];
  end
endmodule
`default_nettype wire

/* verification/ctw_can_wake_ctrl_bench.sv */
// bench: txrx, rx-only, slew, txd timeout, single and pattern wake
// assumes host model and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module ctw_can_wake_ctrl_bench;
  logic i_mclk = 0, rst = 1, nrm = 1, cv = 0, we = 0, sps = 1, clr = 0, wrx = 0;
  logic go = 0, brk = 0, bd = 0, sup = 1;
  logic [1:0] md = 1, ss = 0;
  logic [7:0] b = 0, wk = 0;
  wire htx, rxd, den, dd, to, wf, wi, cw;
  wire [1:0] sl;
  int seed = 51447, fail_count = 0, compares = 0, cyc = 0;
  always #10 i_mclk = ~i_mclk;
  ctw_host #(.BIT(10)) i_ctw_host (.i_mclk(i_mclk), .i_go(go), .i_byte(b), .o_txd(htx));
  ctw_can_wake_ctrl #(.WINDOW_CYC(16'd600), .TXD_DOM_CYC(16'd120)) i_ctw_can_wake_ctrl (
    .i_mclk(i_mclk), .i_sys_rst(rst), .i_chip_normal(nrm), .i_can_mode(md), .i_slew_sel(ss),
    .i_slew_cfg_valid(cv), .i_wake_en(we), .i_single_pulse_wake_select(sps),
    .i_can_supply_on(sup), .i_wake_flag_clr(clr), .i_txd(htx & !brk),
    .i_bus_diff_dom(dd | bd), .i_wake_rx_dom(wrx), .o_rxd(rxd), .o_drv_en(den),
    .o_drv_dom(dd), .o_rx_en(), .o_rin_gnd(), .o_split_en(), .o_wake_rx_en(), .o_slew(sl),
    .o_txd_dom_timeout(to), .o_wake_flag(wf), .o_wake_int(wi), .o_chip_wake(cw));
  task cy(input int n); repeat (n) @(posedge i_mclk); #2; endtask
  task ck(input string n, input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task give_verdict;
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task pl(input int w, g); wrx = 1; cy(w); wrx = 0; cy(g); endtask
  // code 3 is not a setting, so it falls back to fastest
  function logic [7:0] xs(input int s); return (s == 3) ? 8'h0 : 8'(s); endfunction
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (wi === 1'b1 && cw === 1'b1) wk <= wk + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    cy(6);
    rst = 0;
    ck("rxd", rxd, 1);
    ck("slew", sl, 0);
    cy(10);
    ck("drv_en", den, 1);
    repeat (6) begin
      b = 8'($random(seed));
      go = 1;
      cy(1);
      go = 0;
      cy(8);
      for (int k = 7; k >= 0; k--) begin
        ck("dom", dd, !b[k]);
        cy(10);
      end
    end
    brk = 1;
    cy(130);
    ck("timeout", to, 1);
    brk = 0;
    cy(8);
    ck("timeout", to, 0);
    sup = 0;
    cy(3);
    ck("drv_en", den, 0);
    sup = 1;
    md = 2;
    repeat (8) begin
      bd = 1'($random(seed));
      cy(8);
      ck("rxd", rxd, !bd);
    end
    bd = 0;
    cv = 1;
    for (int s = 0; s < 4; s++) begin
      ss = 2'(s);
      cy(2);
      ck("slew", sl, xs(s));
    end
    md = 3;
    nrm = 0;
    we = 1;
    cy(4);
    pl(80, 20);
    pl(120, 20);
    ck("wake", wk, 1);
    ck("flag", wf, 1);
    clr = 1;
    cy(1);
    clr = 0;
    ck("flag", wf, 0);
    wk = 0;
    sps = 0;
    repeat (3) pl(20, 40);
    pl(40, 60);
    pl(40, 700);
    pl(40, 60);
    pl(40, 60);
    ck("wake", wk, 0);
    pl(40, 60);
    ck("wake", wk, 1);
    we = 0;
    repeat (3) pl(40, 60);
    ck("wake", wk, 1);
    md = 1;
    nrm = 1;
    cy(10);
    ck("dom", dd, 0);
    ck("drv_en", den, 1);
    give_verdict;
  end
endmodule
`default_nettype wire
